// >>> rtl/pbg_port.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps

module pbg_port
   import pbg_pkg::*;
(
   input  wire logic       CLOCK_IN,
   input  wire logic       RESETN_IN,
   input  wire logic       WARM_RESET_IN,
   input  wire logic       ANALOG_DEFAULT_SELECT_IN,
   input  wire logic [2:0] ADDR_IN,
   input  wire logic [7:0] WDATA_IN,
   input  wire logic       WR_IN,
   input  wire logic       RD_IN,
   input  wire logic       MOVE_ACCESS_IN,
   output logic      [7:0] RDATA_OUT,
   input  wire logic [7:0] PIN_IN,
   output logic      [7:0] PIN_OUT,
   output logic      [7:0] PIN_OE_OUT,
   output logic      [7:0] PULLUP_OUT,
   output logic            CHANGE_IRQ_OUT,
   output logic            WAKE_OUT
);

   // ***********************************************************
   // Registers
   // ***********************************************************
   logic [7:0]  dir_r;
   logic [7:0]  latch_r;
   logic [7:0]  pu_en_r;
   logic [3:0]  chg_en_r;
   logic        pu_dis_r;
   logic        irq_en_r;
   logic        flag_r;
   logic        flag_nxt;
   logic [4:0]  analog_r;
   logic        strap_done_r;
   logic [7:0]  rdata_r;

   // ***********************************************************
   // Pin input synchroniser
   // ***********************************************************
   logic [7:0]  pin_sync;

   pbg_sync #(
      .W (PBG_PORT_W)
   ) u_pin_sync (
      .clk_in   (CLOCK_IN),
      .rst_n_in (RESETN_IN),
      .d_in     (PIN_IN),
      .q_out    (pin_sync)
   );

   // ***********************************************************
   // Address decode
   // ***********************************************************
   wire sel_pins   = (ADDR_IN == PBG_ADDR_PINS);
   wire sel_dir    = (ADDR_IN == PBG_ADDR_DIR);
   wire sel_latch  = (ADDR_IN == PBG_ADDR_LATCH);
   wire sel_pullup = (ADDR_IN == PBG_ADDR_PULLUP);
   wire sel_chg    = (ADDR_IN == PBG_ADDR_CHG_EN);
   wire sel_ctrl   = (ADDR_IN == PBG_ADDR_CTRL);
   wire sel_analog = (ADDR_IN == PBG_ADDR_ANALOG);

   wire wr_pins    = WR_IN & sel_pins;
   wire wr_dir     = WR_IN & sel_dir;
   wire wr_latch   = WR_IN & sel_latch;
   wire wr_pullup  = WR_IN & sel_pullup;
   wire wr_chg     = WR_IN & sel_chg;
   wire wr_ctrl    = WR_IN & sel_ctrl;
   wire wr_analog  = WR_IN & sel_analog;

   // ***********************************************************
   // Pin drivers and pull-ups
   // ***********************************************************
   assign PIN_OE_OUT = ~dir_r;
   assign PIN_OUT    = latch_r;

   // Pull-up only on inputs, only when enabled and not globally off
   assign PULLUP_OUT = pu_en_r & dir_r
                     & {PBG_PORT_W{~pu_dis_r}};

   // Analog pins have their digital buffer off and read zero
   wire [7:0] pin_digital = pin_sync & ~{3'h0, analog_r};

   // ***********************************************************
   // Change detection on the upper four pins
   // ***********************************************************
   // Snapshot refreshed by any pins access outside a move
   wire refresh = (WR_IN | RD_IN) & sel_pins
                & ~MOVE_ACCESS_IN;

   wire [3:0] chg_active = chg_en_r
                         & dir_r[7:4];
   wire [3:0] mismatch;

   genvar gi;
   generate
      for (gi = 0; gi < PBG_CHG_W; gi++) begin : g_chg
         pbg_change_det u_det (
            .clk_in       (CLOCK_IN),
            .por_n_in     (RESETN_IN),
            .pin_in       (pin_digital[PBG_CHG_LSB + gi]),
            .active_in    (chg_active[gi]),
            .refresh_in   (refresh),
            .mismatch_out (mismatch[gi])
         );
      end
   endgenerate

   // A change landing in the reading cycle is absorbed by the
   // snapshot and may never raise the flag
   wire chg_event = |mismatch;

   // Set wins over a software clear in the same cycle
   assign flag_nxt = chg_event
                   | (wr_ctrl ? WDATA_IN[PBG_CTRL_FLAG_BIT]
                              : flag_r);

   // Combinational from flops so it needs no running clock edge
   assign CHANGE_IRQ_OUT = flag_r & irq_en_r;
   assign WAKE_OUT       = CHANGE_IRQ_OUT;

   // ***********************************************************
   // Register writes
   // ***********************************************************
   // Warm resets restore configuration except the analog selection, and leave the snapshot
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         dir_r    <= PBG_DIR_RST;
         latch_r  <= PBG_LATCH_RST;
         pu_en_r  <= PBG_PULLUP_RST;
         pu_dis_r <= PBG_PU_DIS_RST;
         chg_en_r <= PBG_CHG_EN_RST;
         irq_en_r <= 1'b0;
         flag_r   <= 1'b0;
      end else if (WARM_RESET_IN) begin
         dir_r    <= PBG_DIR_RST;
         latch_r  <= PBG_LATCH_RST;
         pu_en_r  <= PBG_PULLUP_RST;
         pu_dis_r <= PBG_PU_DIS_RST;
         chg_en_r <= PBG_CHG_EN_RST;
         irq_en_r <= 1'b0;
         flag_r   <= chg_event;
      end else begin
         if (wr_dir) begin
            dir_r <= WDATA_IN;
         end
         if (wr_latch || wr_pins) begin
            latch_r <= WDATA_IN;
         end
         if (wr_pullup) begin
            pu_en_r <= WDATA_IN;
         end
         if (wr_chg) begin
            chg_en_r <= WDATA_IN[7:4];
         end
         if (wr_ctrl) begin
            pu_dis_r <= WDATA_IN[PBG_CTRL_PU_DIS_BIT];
            irq_en_r <= WDATA_IN[PBG_CTRL_IRQ_EN_BIT];
         end
         flag_r <= flag_nxt;
      end
   end

   // ***********************************************************
   // Analog selection, strap caught after power-on release
   // ***********************************************************
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         analog_r     <= PBG_ANA_ALL;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         analog_r     <= ANALOG_DEFAULT_SELECT_IN
                         ? PBG_ANA_NONE : PBG_ANA_ALL;
         strap_done_r <= 1'b1;
      end else if (wr_analog) begin
         analog_r     <= WDATA_IN[4:0];
      end
   end

   // ***********************************************************
   // Read data, valid only in the cycle after the strobe
   // ***********************************************************
   wire [7:0] ctrl_word = {pu_dis_r, 2'h0, irq_en_r, 3'h0, flag_r};

   // Unmapped addresses read as zero
   wire [7:0] rd_mux =
        sel_pins   ? pin_digital :
        sel_dir    ? dir_r :
        sel_latch  ? latch_r :
        sel_pullup ? pu_en_r :
        sel_chg    ? {chg_en_r, 4'h0} :
        sel_ctrl   ? ctrl_word :
        sel_analog ? {3'h0, analog_r} :
                     PBG_RDATA_IDLE;

   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         rdata_r <= PBG_RDATA_IDLE;
      end else begin
         rdata_r <= RD_IN ? rd_mux : PBG_RDATA_IDLE;
      end
   end

   assign RDATA_OUT = rdata_r;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RESETN_IN);

   sequence s_refresh;
      refresh;
   endsequence

   sequence s_hold_pins;
      ##1 $stable(pin_digital[7:4]);
   endsequence

   sequence s_latch_read;
      RD_IN && sel_latch;
   endsequence

   a_dir_input_off: assert property (
      PIN_OE_OUT == ~dir_r)
      else $error("Driver enabled on an input pin");

   a_drive_latch: assert property (
      (PIN_OUT & PIN_OE_OUT) == (latch_r & ~dir_r))
      else $error("Output pin not driving latch value");

   a_latch_readback: assert property (
      s_latch_read |=> RDATA_OUT == $past(latch_r))
      else $error("Latch read did not return latch");

   a_pullup_gate: assert property (
      (PULLUP_OUT & ~pu_en_r) == 8'h00)
      else $error("Pull-up on without enable bit");

   a_global_pu_off: assert property (
      pu_dis_r |-> PULLUP_OUT == 8'h00)
      else $error("Pull-up on while globally disabled");

   a_pullup_output: assert property (
      (PULLUP_OUT & ~dir_r) == 8'h00)
      else $error("Pull-up on an output pin");

   a_analog_zero: assert property (
      RD_IN && sel_pins |=>
         (RDATA_OUT[4:0] & $past(analog_r)) == 5'h00)
      else $error("Analog pin read as nonzero");

   a_irq_gate: assert property (
      !irq_en_r |-> !CHANGE_IRQ_OUT)
      else $error("Request while global enable clear");

   a_excluded_pins: assert property (
      (mismatch & ~(chg_en_r & dir_r[7:4])) == 4'h0)
      else $error("Excluded pin caused a mismatch");

   a_mismatch_sets: assert property (
      chg_event |=> flag_r)
      else $error("Mismatch did not set the flag");

   a_refresh_ends: assert property (
      s_refresh ##0 s_hold_pins |-> mismatch == 4'h0)
      else $error("Port access did not end mismatch");

   a_flag_sticky: assert property (
      flag_r && !wr_ctrl && !WARM_RESET_IN |=> flag_r)
      else $error("Flag dropped without a clear");

   a_read_one_cycle: assert property (
      !RD_IN |=> RDATA_OUT == PBG_RDATA_IDLE)
      else $error("Read data outside its cycle");

   a_pullup_active: assert property (
      !pu_dis_r |-> PULLUP_OUT == (pu_en_r & dir_r))
      else $error("Enabled pull-up missing on an input");

   a_pins_readback: assert property (
      RD_IN && sel_pins |=> RDATA_OUT == $past(pin_digital))
      else $error("Pins read did not return pin levels");

   a_dir_write: assert property (
      wr_dir && !WARM_RESET_IN |=> dir_r == $past(WDATA_IN))
      else $error("Direction write lost");

   a_latch_write: assert property (
      (wr_latch || wr_pins) && !WARM_RESET_IN |=> PIN_OUT == $past(WDATA_IN))
      else $error("Latch write not driven to pins");

   a_clear_sticks: assert property (
      wr_ctrl && !WDATA_IN[PBG_CTRL_FLAG_BIT] && !chg_event |=> !flag_r)
      else $error("Flag clear without mismatch did not stick");

   a_warm_flag: assert property (
      WARM_RESET_IN |=> flag_r == $past(chg_event))
      else $error("Warm reset flag does not follow mismatch");

   a_warm_pullup: assert property (
      WARM_RESET_IN |=> PULLUP_OUT == 8'h00)
      else $error("Pull-up on after warm reset");

   a_irq_request: assert property (
      flag_r && irq_en_r |-> CHANGE_IRQ_OUT)
      else $error("Request missing with flag and enable set");

   a_wake_request: assert property (
      CHANGE_IRQ_OUT |-> WAKE_OUT)
      else $error("Wake missing while request stands");

   a_strap_load: assert property (
      $rose(strap_done_r) |-> analog_r ==
         ($past(ANALOG_DEFAULT_SELECT_IN) ? PBG_ANA_NONE : PBG_ANA_ALL))
      else $error("Analog default not taken from strap");

   a_no_active_quiet: assert property (
      chg_active == 4'h0 && !flag_r && !wr_ctrl |=> !flag_r)
      else $error("Flag rose with no pin taking part");

endmodule : pbg_port

// >>> rtl/pbg_pkg.sv
package pbg_pkg;

   // ***********************************************************
   // Register map, one byte per address
   // ***********************************************************
   localparam logic [2:0] PBG_ADDR_PINS    = 3'h0;
   localparam logic [2:0] PBG_ADDR_DIR     = 3'h1;
   localparam logic [2:0] PBG_ADDR_LATCH   = 3'h2;
   localparam logic [2:0] PBG_ADDR_PULLUP  = 3'h3;
   localparam logic [2:0] PBG_ADDR_CHG_EN  = 3'h4;
   localparam logic [2:0] PBG_ADDR_CTRL    = 3'h5;
   localparam logic [2:0] PBG_ADDR_ANALOG  = 3'h6;

   // ***********************************************************
   // Field positions of the control register
   // ***********************************************************
   localparam int PBG_CTRL_PU_DIS_BIT = 7;
   localparam int PBG_CTRL_IRQ_EN_BIT = 4;
   localparam int PBG_CTRL_FLAG_BIT   = 0;

   // ***********************************************************
   // Widths and values after reset
   // ***********************************************************
   localparam int          PBG_PORT_W      = 8;
   localparam int          PBG_CHG_W       = 4;
   localparam int          PBG_CHG_LSB     = 4;
   localparam int          PBG_ANA_W       = 5;
   localparam logic [7:0]  PBG_DIR_RST     = 8'hFF;
   localparam logic [7:0]  PBG_LATCH_RST   = 8'h00;
   localparam logic [7:0]  PBG_PULLUP_RST  = 8'hFF;
   localparam logic [3:0]  PBG_CHG_EN_RST  = 4'h0;
   localparam logic        PBG_PU_DIS_RST  = 1'b1;
   localparam logic [4:0]  PBG_ANA_ALL     = 5'h1F;
   localparam logic [4:0]  PBG_ANA_NONE    = 5'h00;
   localparam logic [7:0]  PBG_RDATA_IDLE  = 8'h00;

endpackage : pbg_pkg

// >>> rtl/pbg_sync.sv
`timescale 1ns/1ps

module pbg_sync #(
   parameter int W = 8
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= '0;
         q_out  <= '0;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end

endmodule : pbg_sync

// >>> rtl/pbg_change_det.sv
`timescale 1ns/1ps

module pbg_change_det (
   input  wire logic clk_in,
   input  wire logic por_n_in,
   input  wire logic pin_in,
   input  wire logic active_in,
   input  wire logic refresh_in,
   output logic      mismatch_out
);

   logic snap_r;

   // Only power-on clears the snapshot; warm resets never touch it
   always_ff @(posedge clk_in or negedge por_n_in) begin
      if (!por_n_in) begin
         snap_r <= 1'b0;
      end else if (refresh_in) begin
         snap_r <= pin_in;
      end
   end

   assign mismatch_out = active_in & ~refresh_in & (pin_in != snap_r);

endmodule : pbg_change_det

// >>> sim/pbg_pin_model.sv
`timescale 1ns/1ps

module pbg_pin_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] pin_out_in,
   input  wire logic [7:0] pin_oe_in,
   input  wire logic [7:0] pullup_in,
   input  wire logic [7:0] ext_val_in,
   input  wire logic [7:0] ext_en_in,
   output logic      [7:0] level_out
);
   logic [7:0] float_r = 8'h00;

   // Undriven pins without a pull-up wander, so a stale level never passes as valid
   always @(posedge clk_in) begin
      float_r <= ~level_out;
   end

   assign level_out = (pin_oe_in & pin_out_in)
                    | (~pin_oe_in & ext_en_in & ext_val_in)
                    | (~pin_oe_in & ~ext_en_in & (pullup_in | float_r));
endmodule : pbg_pin_model

// >>> sim/tb.sv
`timescale 1ns/1ps

module tb
   import pbg_pkg::*;
;
   logic       clk   = 1'b0;
   logic       rst_n = 1'b0;
   logic       warm  = 1'b0;
   logic       strap = 1'b0;
   logic [2:0] addr  = 3'h0;
   logic [7:0] wd    = 8'h00;
   logic       wr    = 1'b0;
   logic       rd    = 1'b0;
   logic       mv    = 1'b0;
   logic [7:0] ext_v = 8'hFF;
   logic [7:0] ext_e = 8'hFF;
   logic [7:0] rdata, lvl, pout, poe, pu;
   logic       irq, wake;
   logic [7:0] d, l, e;
   logic       dis;
   int         n_errors    = 0;
   int         check_count = 0;

   pbg_port u_dut (
      .CLOCK_IN                 (clk),
      .RESETN_IN                (rst_n),
      .WARM_RESET_IN            (warm),
      .ANALOG_DEFAULT_SELECT_IN (strap),
      .ADDR_IN                  (addr),
      .WDATA_IN                 (wd),
      .WR_IN                    (wr),
      .RD_IN                    (rd),
      .MOVE_ACCESS_IN           (mv),
      .RDATA_OUT                (rdata),
      .PIN_IN                   (lvl),
      .PIN_OUT                  (pout),
      .PIN_OE_OUT               (poe),
      .PULLUP_OUT               (pu),
      .CHANGE_IRQ_OUT           (irq),
      .WAKE_OUT                 (wake)
   );

   pbg_pin_model u_pins (
      .clk_in     (clk),
      .pin_out_in (pout),
      .pin_oe_in  (poe),
      .pullup_in  (pu),
      .ext_val_in (ext_v),
      .ext_en_in  (ext_e),
      .level_out  (lvl)
   );

   initial begin
      forever #50 clk = ~clk;
   end

   // ***********************************************************
   // Bus tasks and expectations
   // ***********************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      wr   <= 1'b1;
      addr <= a;
      wd   <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_reg

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : ticks

   task automatic set_ext(input logic [7:0] v);
      @(posedge clk);
      ext_v <= v;
   endtask : set_ext

   task automatic do_reset(input logic s);
      @(posedge clk);
      rst_n <= 1'b0;
      strap <= s;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      ticks(2);
   endtask : do_reset

   function automatic logic [7:0] exp_pu(logic [7:0] pe, logic [7:0] dr,
                                         logic off);
      return off ? 8'h00 : (pe & dr);
   endfunction : exp_pu

   task automatic conclude;
      $display("Counts: %0d checks, %0d errors", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   initial begin
      #(100 * 20000);
      n_errors++;
      conclude();
   end

   // ***********************************************************
   // Tests
   // ***********************************************************
   initial begin
      void'($urandom(32'h0d1e20b5));
      do_reset(1'b0);
      chk(poe, 8'h00);
      chk(pu, 8'h00);
      rd_reg(PBG_ADDR_DIR, 8'hFF);
      rd_reg(PBG_ADDR_CTRL, 8'h80);
      rd_reg(PBG_ADDR_ANALOG, 8'h1F);
      rd_reg(PBG_ADDR_PINS, 8'hE0);
      rd_reg(3'h7, 8'h00);
      $display("Test reset finished");
      wr_reg(PBG_ADDR_ANALOG, 8'h00);
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         l = 8'($urandom);
         e = 8'($urandom);
         set_ext(e);
         wr_reg(PBG_ADDR_DIR, d);
         wr_reg(PBG_ADDR_LATCH, l);
         ticks(3);
         chk(poe, ~d);
         chk(pout, l);
         rd_reg(PBG_ADDR_LATCH, l);
         rd_reg(PBG_ADDR_PINS, (d & e) | (~d & l));
      end
      $display("Test direction finished");
      @(posedge clk);
      ext_e <= 8'h00;
      for (int i = 0; i < 8; i++) begin
         d   = (i == 1) ? 8'h00 : (i == 0) ? 8'hFF : 8'($urandom);
         l   = (i < 2) ? 8'hFF : 8'($urandom);
         dis = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
         wr_reg(PBG_ADDR_DIR, d);
         wr_reg(PBG_ADDR_PULLUP, l);
         wr_reg(PBG_ADDR_CTRL, {dis, 7'h00});
         ticks(1);
         chk(pu, exp_pu(l, d, dis));
         chk(lvl & pu, pu);
      end
      @(posedge clk);
      ext_e <= 8'hFF;
      $display("Test pullup finished");
      // Pins move only between reads, and nothing polls while waiting
      wr_reg(PBG_ADDR_DIR, 8'hFF);
      wr_reg(PBG_ADDR_CHG_EN, 8'hF0);
      set_ext(8'h20);
      ticks(3);
      rd_reg(PBG_ADDR_PINS, 8'h20);
      wr_reg(PBG_ADDR_CTRL, 8'h10);
      ticks(2);
      chk({7'h00, irq}, 8'h00);
      set_ext(8'h00);
      ticks(5);
      chk({7'h00, irq}, 8'h01);
      chk({7'h00, wake}, 8'h01);
      wr_reg(PBG_ADDR_CTRL, 8'h10);
      ticks(2);
      chk({7'h00, irq}, 8'h01);
      @(posedge clk);
      mv <= 1'b1;
      rd_reg(PBG_ADDR_PINS, 8'h00);
      @(posedge clk);
      mv <= 1'b0;
      wr_reg(PBG_ADDR_CTRL, 8'h10);
      ticks(2);
      chk({7'h00, irq}, 8'h01);
      rd_reg(PBG_ADDR_PINS, 8'h00);
      wr_reg(PBG_ADDR_CTRL, 8'h10);
      ticks(2);
      chk({7'h00, irq}, 8'h00);
      wr_reg(PBG_ADDR_CTRL, 8'h00);
      set_ext(8'h80);
      ticks(5);
      chk({7'h00, irq}, 8'h00);
      rd_reg(PBG_ADDR_CTRL, 8'h01);
      rd_reg(PBG_ADDR_PINS, 8'h80);
      wr_reg(PBG_ADDR_CTRL, 8'h10);
      wr_reg(PBG_ADDR_CHG_EN, 8'h70);
      set_ext(8'h00);
      ticks(5);
      chk({7'h00, irq}, 8'h00);
      wr_reg(PBG_ADDR_LATCH, 8'h00);
      wr_reg(PBG_ADDR_DIR, 8'hEF);
      wr_reg(PBG_ADDR_CHG_EN, 8'hF0);
      rd_reg(PBG_ADDR_PINS, 8'h00);
      wr_reg(PBG_ADDR_CTRL, 8'h10);
      wr_reg(PBG_ADDR_LATCH, 8'h10);
      ticks(5);
      chk({7'h00, irq}, 8'h00);
      $display("Test change finished");
      wr_reg(PBG_ADDR_DIR, 8'hFF);
      set_ext(8'h20);
      ticks(3);
      rd_reg(PBG_ADDR_PINS, 8'h20);
      set_ext(8'h00);
      ticks(5);
      @(posedge clk);
      warm <= 1'b1;
      @(posedge clk);
      warm <= 1'b0;
      // Snapshot kept, so the old pin level still mismatches
      wr_reg(PBG_ADDR_CHG_EN, 8'hF0);
      wr_reg(PBG_ADDR_CTRL, 8'h10);
      ticks(4);
      chk({7'h00, irq}, 8'h01);
      // Writing the pins register lands in the latch and refreshes too
      wr_reg(PBG_ADDR_PINS, 8'h5A);
      wr_reg(PBG_ADDR_CTRL, 8'h10);
      ticks(2);
      chk({7'h00, irq}, 8'h00);
      chk(pout, 8'h5A);
      $display("Test warm reset finished");
      set_ext(8'hFF);
      do_reset(1'b1);
      rd_reg(PBG_ADDR_ANALOG, 8'h00);
      rd_reg(PBG_ADDR_PINS, 8'hFF);
      $display("Test strap finished");
      conclude();
   end
endmodule : tb
